// ===== dv/sdlc_buf_regs_tb.sv
// Testbench: register access, transmit fetch and receive store of the buffer register bank
`timescale 1ns/10ps
`default_nettype none
module sdlc_buf_regs_tb;
   logic        clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, txr = 0, e;
   logic        rxs = 0, rxcv = 0, rxbv = 0, rxe = 0, rxa = 0;
   logic [7:0]  paddr = 8'h00, rxc = 8'h00, rxb = 8'h00, ra, rw, rr, txd, txc, sta;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic        pready, pslverr, we, re, txs, txv, txe, tce;
   int          bad_count = 0, num_checks = 0, nend = 0, nst = 0;
   logic [7:0]  txq [$];
   // ==========================================================
   // Clock, design and partner
   always #50 clk = ~clk;
   sdlc_buf_regs DUT (.CLK_SYS(clk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .RAM_ADDR(ra), .RAM_WDATA(rw), .RAM_WE(we), .RAM_RE(re), .RAM_RDATA(rr), .STATION_ADDR(sta),
      .TX_START(txs), .TX_CTRL(txc), .TX_CTRL_EN(tce), .TX_DATA(txd), .TX_VALID(txv), .TX_READY(txr),
      .TX_END(txe), .RX_START(rxs), .RX_CTRL_VALID(rxcv), .RX_CTRL_DATA(rxc), .RX_BYTE_VALID(rxbv),
      .RX_BYTE(rxb), .RX_END(rxe), .RX_ABORT(rxa));
   sdlc_ram_model ram (.clk(clk), .addr(ra), .wdata(rw), .we(we), .re(re), .rdata(rr));
   // Frame engine stalls every other cycle, so valid must be held
   always @(posedge clk) begin
      if (txv === 1'b1 && txr === 1'b1) txq.push_back(txd);
      if (txe === 1'b1) nend++;
      if (txs === 1'b1) nst++;
      txr <= ~txr;
   end
   // ==========================================================
   // Shared tasks
   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // Poll the mode register until the device drops a handshake bit
   task wait_clr(input int b);
      int n;
      n = 0;
      do apb(1'b0, sdlc_buf_pkg::MODE_OFS, 32'h0); while (r[b] !== 1'b0 && ++n < 100);
      chk(32'(r[b]), 32'h0);
   endtask : wait_clr
   task rx_cyc(input logic [4:0] f, input logic [7:0] d);
      @(posedge clk);
      {rxs, rxcv, rxbv, rxe, rxa} <= f;
      rxc <= d;
      rxb <= d;
   endtask : rx_cyc
   task tx_frame(input logic [7:0] s, input logic [7:0] l, input int cnt);
      txq.delete();
      apb(1'b1, sdlc_buf_pkg::TXS_OFS, 32'(s));
      apb(1'b1, sdlc_buf_pkg::TXL_OFS, 32'(l));
      apb(1'b1, sdlc_buf_pkg::MODE_OFS, 32'h80);
      wait_clr(7);
      chk(32'(txq.size()), 32'(cnt));
      for (int i = 0; i < cnt; i++) chk(32'(txq[i]), 32'(s + 8'(i)) ^ 32'h5a);
   endtask : tx_frame
   task rx_frame(input logic [7:0] s, input logic [7:0] l, input int n, input int k,
                 input logic [7:0] m, input logic [7:0] c);
      apb(1'b1, sdlc_buf_pkg::RXS_OFS, 32'(s));
      apb(1'b1, sdlc_buf_pkg::RXL_OFS, 32'(l));
      apb(1'b1, sdlc_buf_pkg::MODE_OFS, 32'(m));
      rx_cyc(5'h10, 8'h00);
      rx_cyc(5'h08, c);
      for (int i = 0; i < n; i++) rx_cyc(5'h04, 8'ha0 + 8'(i));
      rx_cyc(5'h02, 8'h00);
      rx_cyc(5'h00, 8'h00);
      wait_clr(6);
      for (int i = 0; i <= n; i++) chk(32'(ram.mem[s + 8'(i)]),
         i < k ? 32'(8'ha0 + 8'(i)) : 32'(s + 8'(i)) ^ 32'h5a);
      apb(1'b0, sdlc_buf_pkg::RFL_OFS, 32'h0);
      chk(r, 32'(k));
      apb(1'b0, sdlc_buf_pkg::RCB_OFS, 32'h0);
      chk(r, 32'(c));
   endtask : rx_frame
   // ==========================================================
   // Scenarios
   task t_regs;
      for (int i = 0; i < 8; i++) begin
         apb(1'b0, 8'(4 * i), 32'h0);
         chk(r, 32'h0);
      end
      for (int i = 0; i < 8; i++) apb(1'b1, 8'(4 * i), 32'(8'h11 * (i + 1)));
      for (int i = 0; i < 8; i++) begin
         apb(1'b0, 8'(4 * i), 32'h0);
         chk(r, 32'(8'h11 * (i + 1)));
      end
      chk(32'(sta), 32'h22);
      apb(1'b1, sdlc_buf_pkg::RCB_OFS, 32'hff);
      apb(1'b0, sdlc_buf_pkg::RCB_OFS, 32'h0);
      chk(r, 32'h0);
      apb(1'b1, sdlc_buf_pkg::STATE_OFS, 32'hff);
      apb(1'b0, sdlc_buf_pkg::STATE_OFS, 32'h0);
      chk(r, 32'h0);
      apb(1'b0, 8'h3c, 32'h0);
      chk(32'(e), 32'h1);
      $display("test regs done");
   endtask : t_regs
   task t_tx;
      apb(1'b1, sdlc_buf_pkg::TXC_OFS, 32'h3c);
      tx_frame(8'h10, 8'h03, 3);
      chk(32'({tce, txc}), 32'h13c);
      tx_frame(8'hbe, 8'h05, 2);
      tx_frame(8'h20, 8'h00, 0);
      chk(32'(nend), 32'h3);
      chk(32'(nst), 32'h3);
      apb(1'b0, sdlc_buf_pkg::REM_OFS, 32'h0);
      chk(r, 32'h0);
      $display("test tx done");
   endtask : t_tx
   task t_rx;
      rx_frame(8'h40, 8'h02, 3, 2, 8'h40, 8'h13);
      rx_frame(8'hbe, 8'h05, 3, 2, 8'h40, 8'h13);
      rx_frame(8'h50, 8'h00, 1, 0, 8'h40, 8'h13);
      apb(1'b0, sdlc_buf_pkg::SEQ_OFS, 32'h0);
      chk(r, 32'h11);
      $display("test rx done");
   endtask : t_rx
   // Aborted frame keeps the empty flag; automatic mode counter steps and errors
   task t_auto;
      apb(1'b1, sdlc_buf_pkg::RXL_OFS, 32'h1);
      apb(1'b1, sdlc_buf_pkg::MODE_OFS, 32'h40);
      rx_cyc(5'h10, 8'h00);
      rx_cyc(5'h04, 8'h77);
      rx_cyc(5'h01, 8'h00);
      rx_cyc(5'h00, 8'h00);
      apb(1'b0, sdlc_buf_pkg::MODE_OFS, 32'h0);
      chk(r, 32'h40);
      apb(1'b1, sdlc_buf_pkg::SEQ_OFS, 32'hee);
      rx_frame(8'h60, 8'h01, 1, 1, 8'h42, 8'h0e);
      apb(1'b0, sdlc_buf_pkg::SEQ_OFS, 32'h0);
      chk(r, 32'h00);
      rx_frame(8'h60, 8'h01, 1, 1, 8'h42, 8'ha6);
      apb(1'b0, sdlc_buf_pkg::SEQ_OFS, 32'h0);
      chk(r, 32'h11);
      apb(1'b0, sdlc_buf_pkg::MODE_OFS, 32'h0);
      chk(r, 32'h0);
      $display("test auto done");
   endtask : t_auto
   task results;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : results
   // Main sequence, then a watchdog well past its expected span
   initial begin
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      t_regs;
      t_tx;
      t_rx;
      t_auto;
      results;
   end
   initial begin
      #500000;
      bad_count++;
      results;
   end
endmodule : sdlc_buf_regs_tb
`default_nettype wire

// ===== dv/sdlc_ram_model.sv
// Internal RAM model for the buffer sequencer: asynchronous read, clocked write
`timescale 1ns/10ps
`default_nettype none
module sdlc_ram_model (
   input  wire logic       clk,
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       we,
   input  wire logic       re,
   output logic      [7:0] rdata
);
   logic [7:0] mem [0:255];
   // ==========================================================
   // Known fill, so every fetched byte can be predicted
   initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
   // Data only valid under the read strobe; otherwise the inverse, never a stale match
   assign rdata = re ? mem[addr] : ~mem[addr];
   // Bytes stored by the receive path
   always @(posedge clk) if (we) mem[addr] <= wdata;
endmodule : sdlc_ram_model
`default_nettype wire

// ===== inc/sdlc_buf_pkg.sv
// Package: offsets, field layouts, reset values and states of the SDLC buffer register bank
package sdlc_buf_pkg;
   // ==========================================================
   // Register byte offsets on APB
   localparam logic [7:0] SEQ_OFS    = 8'h00;
   localparam logic [7:0] STATION_ADDRESS_OFS   = 8'h04;
   localparam logic [7:0] TXS_OFS    = 8'h08;
   localparam logic [7:0] TXL_OFS    = 8'h0c;
   localparam logic [7:0] TXC_OFS    = 8'h10;
   localparam logic [7:0] RXS_OFS    = 8'h14;
   localparam logic [7:0] RXL_OFS    = 8'h18;
   localparam logic [7:0] RFL_OFS    = 8'h1c;
   localparam logic [7:0] RCB_OFS    = 8'h20;
   localparam logic [7:0] REM_OFS    = 8'h24;
   localparam logic [7:0] Q0_OFS     = 8'h28;
   localparam logic [7:0] Q1_OFS     = 8'h2c;
   localparam logic [7:0] Q2_OFS     = 8'h30;
   localparam logic [7:0] STATE_OFS  = 8'h34;
   localparam logic [7:0] MODE_OFS   = 8'h38;
   // ==========================================================
   // Field positions in the mode/status register
   localparam int TBF_BIT = 7;
   localparam int RBE_BIT = 6;
   localparam int NB_BIT  = 2;
   localparam int AM_BIT  = 1;
   // ==========================================================
   // Reset values and limits
   localparam logic [7:0] REG_RST  = 8'h00;
   localparam logic [7:0] RAM_TOP  = 8'hbf;
   localparam logic [8:0] RAM_TOP9 = 9'h0bf;
   localparam int         Q_DEPTH  = 3;
   // ==========================================================
   // Sequence register layout, bit 7 down to bit 0
   typedef struct packed {
      logic [2:0] ns;
      logic       send_sequence_error;
      logic [2:0] nr;
      logic       receive_sequence_error;
   } seq_t;
   // Software mode and handshake bits
   typedef struct packed {
      logic transmit_buffer_full;
      logic receive_buffer_empty;
      logic nb;
      logic am;
   } mode_t;
   // Frame sequencer, Gray codes in the order listed
   typedef enum logic [2:0] {
      ST_IDLE  = 3'h0,
      ST_FETCH = 3'h1,
      ST_WAIT  = 3'h3,
      ST_SEND  = 3'h2,
      ST_DONE  = 3'h6,
      ST_RXINF = 3'h7,
      ST_DRAIN = 3'h5
   } fstate_t;
endpackage : sdlc_buf_pkg

// ===== rtl/sdlc_buf_regs.sv
// Register bank, buffer sequencer and receive queue of the SDLC serial unit
//
// Function
// - Sequence register: send, error, receive, error fields
// - Acknowledge outside send or send+1 sets error
// - Counters untouched outside automatic mode
// - CPU and unit both update sequence register
// - Transmit bytes fetched from transmit start address
// - Programmed byte count sent, stopping early at RAM top; zero allowed
// - Transmit buffer ends at RAM address 191
// - Flexible mode sends transmit control byte
// - Received bytes stored from receive start address
// - Stored bytes limited to receive length
// - Receive buffer ends at RAM address 191
// - Field length register gets stored count
// - Received control byte loaded, read only
// - Debug counter of bytes remaining
// - Three-entry receive queue, entries readable
// - Frame state readable, never written
// - CPU sets buffer full; unit clears at end
// - CPU sets buffer empty; unit clears on frame
// - Mode bit picks automatic mode; unit clears
`timescale 1ns/10ps
`default_nettype none
module sdlc_buf_regs (
   input  wire logic       CLK_SYS,
   input  wire logic       RESETN,
   input  wire logic       PSEL,
   input  wire logic       PENABLE,
   input  wire logic       PWRITE,
   input  wire logic [7:0] PADDR,
   input  wire logic [31:0] PWDATA,
   output logic      [31:0] PRDATA,
   output logic            PREADY,
   output logic            PSLVERR,
   output logic [7:0]      RAM_ADDR,
   output logic [7:0]      RAM_WDATA,
   output logic            RAM_WE,
   output logic            RAM_RE,
   input  wire logic [7:0] RAM_RDATA,
   output logic [7:0]      STATION_ADDR,
   output logic            TX_START,
   output logic [7:0]      TX_CTRL,
   output logic            TX_CTRL_EN,
   output logic [7:0]      TX_DATA,
   output logic            TX_VALID,
   input  wire logic       TX_READY,
   output logic            TX_END,
   input  wire logic       RX_START,
   input  wire logic       RX_CTRL_VALID,
   input  wire logic [7:0] RX_CTRL_DATA,
   input  wire logic       RX_BYTE_VALID,
   input  wire logic [7:0] RX_BYTE,
   input  wire logic       RX_END,
   input  wire logic       RX_ABORT
);
   // ==========================================================
   // Storage
   sdlc_buf_pkg::seq_t    seq_reg;
   sdlc_buf_pkg::mode_t   mode_reg;
   sdlc_buf_pkg::fstate_t state_reg;
   logic [7:0] station_address_reg, txs_reg, txl_reg, txc_reg, rxs_reg, rxl_reg;
   logic [7:0] rfl_reg, rcb_reg, rem_reg, addr_reg, acc_reg, ctl_hold_reg;
   logic [7:0] q_reg [0:2];
   logic [1:0] q_cnt_reg;
   logic       tx_go, rx_go, rx_done, push, pop, wr_en, seq_wr, mode_wr, fits;
   logic       iframe, sframe, ser_hit, ses_hit, nr_step, ns_step;
   logic [1:0] wr_idx;
   logic [2:0] ns_p, nr_p;
   logic [31:0] rd_mux;
   logic       bad_addr;

   // ==========================================================
   // APB decode; zero wait states, answer registered in setup
   assign wr_en   = PSEL && PENABLE && PWRITE && PREADY && !PSLVERR;
   assign seq_wr  = wr_en && (PADDR == sdlc_buf_pkg::SEQ_OFS);
   assign mode_wr = wr_en && (PADDR == sdlc_buf_pkg::MODE_OFS);

   // Read mux; state and queue are debug views
   always_comb begin
      rd_mux   = 32'h0;
      bad_addr = 1'b0;
      unique case (PADDR)
         sdlc_buf_pkg::SEQ_OFS:   rd_mux[7:0] = seq_reg;
         sdlc_buf_pkg::STATION_ADDRESS_OFS:  rd_mux[7:0] = station_address_reg;
         sdlc_buf_pkg::TXS_OFS:   rd_mux[7:0] = txs_reg;
         sdlc_buf_pkg::TXL_OFS:   rd_mux[7:0] = txl_reg;
         sdlc_buf_pkg::TXC_OFS:   rd_mux[7:0] = txc_reg;
         sdlc_buf_pkg::RXS_OFS:   rd_mux[7:0] = rxs_reg;
         sdlc_buf_pkg::RXL_OFS:   rd_mux[7:0] = rxl_reg;
         sdlc_buf_pkg::RFL_OFS:   rd_mux[7:0] = rfl_reg;
         sdlc_buf_pkg::RCB_OFS:   rd_mux[7:0] = rcb_reg;
         sdlc_buf_pkg::REM_OFS:   rd_mux[7:0] = rem_reg;
         sdlc_buf_pkg::Q0_OFS:    rd_mux[7:0] = q_reg[0];
         sdlc_buf_pkg::Q1_OFS:    rd_mux[7:0] = q_reg[1];
         sdlc_buf_pkg::Q2_OFS:    rd_mux[7:0] = q_reg[2];
         sdlc_buf_pkg::STATE_OFS: rd_mux[7:0] = {5'h00, state_reg};
         sdlc_buf_pkg::MODE_OFS:  rd_mux[7:0] = {mode_reg[3:2], 3'h0, mode_reg.nb, mode_reg.am, 1'b0};
         default:                 bad_addr = 1'b1;
      endcase
   end

   // Bus answer flops
   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         PREADY  <= 1'b0;
         PSLVERR <= 1'b0;
         PRDATA  <= 32'h0;
      end else if (PSEL && !PENABLE) begin
         PREADY  <= 1'b1;
         PSLVERR <= bad_addr;
         PRDATA  <= PWRITE ? 32'h0 : rd_mux;
      end else begin
         PREADY  <= 1'b0;
         PSLVERR <= 1'b0;
      end
   end

   // ==========================================================
   // Plain CPU registers; read-only ones ignore writes
   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         station_address_reg <= sdlc_buf_pkg::REG_RST;
         txs_reg  <= sdlc_buf_pkg::REG_RST;
         txl_reg  <= sdlc_buf_pkg::REG_RST;
         txc_reg  <= sdlc_buf_pkg::REG_RST;
         rxs_reg  <= sdlc_buf_pkg::REG_RST;
         rxl_reg  <= sdlc_buf_pkg::REG_RST;
      end else if (wr_en) begin
         // Software is trusted to write these only while idle
         if (PADDR == sdlc_buf_pkg::STATION_ADDRESS_OFS) station_address_reg <= PWDATA[7:0];
         if (PADDR == sdlc_buf_pkg::TXS_OFS)  txs_reg  <= PWDATA[7:0];
         if (PADDR == sdlc_buf_pkg::TXL_OFS)  txl_reg  <= PWDATA[7:0];
         if (PADDR == sdlc_buf_pkg::TXC_OFS)  txc_reg  <= PWDATA[7:0];
         if (PADDR == sdlc_buf_pkg::RXS_OFS)  rxs_reg  <= PWDATA[7:0];
         if (PADDR == sdlc_buf_pkg::RXL_OFS)  rxl_reg  <= PWDATA[7:0];
      end
   end

   // ==========================================================
   // Received control byte fields
   assign ns_p    = ctl_hold_reg[3:1];
   assign nr_p    = ctl_hold_reg[7:5];
   assign iframe  = !ctl_hold_reg[0];
   assign sframe  = ctl_hold_reg[1:0] == 2'b01;
   assign rx_done = (state_reg == sdlc_buf_pkg::ST_DRAIN) && (q_cnt_reg == 2'd0);
   // Counters only take part in automatic mode with a control field
   assign ser_hit = rx_done && mode_reg.am && !mode_reg.nb && iframe && (ns_p != seq_reg.nr);
   assign nr_step = rx_done && mode_reg.am && !mode_reg.nb && iframe && (ns_p == seq_reg.nr);
   assign ses_hit = rx_done && mode_reg.am && !mode_reg.nb && (iframe || sframe)
                    && (nr_p != seq_reg.ns) && (nr_p != 3'(seq_reg.ns + 3'd1));
   assign ns_step = rx_done && mode_reg.am && !mode_reg.nb && (iframe || sframe)
                    && (nr_p == 3'(seq_reg.ns + 3'd1));

   // Sequence register: CPU write first, unit updates on top so no event is lost
   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         seq_reg <= sdlc_buf_pkg::REG_RST;
      end else begin
         if (seq_wr) seq_reg <= PWDATA[7:0];
         if (ser_hit) seq_reg.receive_sequence_error <= 1'b1;
         if (ses_hit) seq_reg.send_sequence_error <= 1'b1;
         if (nr_step) seq_reg.nr <= 3'(seq_reg.nr + 3'd1);
         if (ns_step) seq_reg.ns <= 3'(seq_reg.ns + 3'd1);
      end
   end

   // Mode bits: the unit's clears follow the CPU write
   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         mode_reg <= '0;
      end else begin
         if (mode_wr) begin
            mode_reg.transmit_buffer_full <= PWDATA[sdlc_buf_pkg::TBF_BIT];
            mode_reg.receive_buffer_empty <= PWDATA[sdlc_buf_pkg::RBE_BIT];
            mode_reg.nb  <= PWDATA[sdlc_buf_pkg::NB_BIT];
            mode_reg.am  <= PWDATA[sdlc_buf_pkg::AM_BIT];
         end
         if (state_reg == sdlc_buf_pkg::ST_DONE) mode_reg.transmit_buffer_full <= 1'b0;
         if (rx_done) mode_reg.receive_buffer_empty <= 1'b0;
         // A broken acknowledge drops back to flexible mode
         if (ses_hit) mode_reg.am <= 1'b0;
      end
   end

   // ==========================================================
   // Frame sequencer; one direction at a time, transmit first
   assign tx_go = (state_reg == sdlc_buf_pkg::ST_IDLE) && mode_reg.transmit_buffer_full;
   assign rx_go = (state_reg == sdlc_buf_pkg::ST_IDLE) && !mode_reg.transmit_buffer_full && mode_reg.receive_buffer_empty && RX_START;
   assign fits  = ({1'b0, rxs_reg} + {1'b0, acc_reg}) <= sdlc_buf_pkg::RAM_TOP9;
   assign push  = (state_reg == sdlc_buf_pkg::ST_RXINF) && RX_BYTE_VALID
                  && (acc_reg < rxl_reg) && fits && (q_cnt_reg != 2'd3);
   assign pop   = ((state_reg == sdlc_buf_pkg::ST_RXINF) || (state_reg == sdlc_buf_pkg::ST_DRAIN))
                  && (q_cnt_reg != 2'd0);

   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         state_reg <= sdlc_buf_pkg::ST_IDLE;
      end else begin
         unique case (state_reg)
            sdlc_buf_pkg::ST_IDLE:
               if (tx_go) state_reg <= sdlc_buf_pkg::ST_FETCH;
               else if (rx_go) state_reg <= sdlc_buf_pkg::ST_RXINF;
            sdlc_buf_pkg::ST_FETCH:
               // Zero length or past the top of RAM: no information field
               if (rem_reg == 8'h00 || addr_reg > sdlc_buf_pkg::RAM_TOP)
                  state_reg <= sdlc_buf_pkg::ST_DONE;
               else state_reg <= sdlc_buf_pkg::ST_WAIT;
            sdlc_buf_pkg::ST_WAIT: state_reg <= sdlc_buf_pkg::ST_SEND;
            sdlc_buf_pkg::ST_SEND:
               if (TX_READY) begin
                  if (addr_reg == sdlc_buf_pkg::RAM_TOP) state_reg <= sdlc_buf_pkg::ST_DONE;
                  else state_reg <= sdlc_buf_pkg::ST_FETCH;
               end
            sdlc_buf_pkg::ST_DONE: state_reg <= sdlc_buf_pkg::ST_IDLE;
            sdlc_buf_pkg::ST_RXINF:
               if (RX_ABORT) state_reg <= sdlc_buf_pkg::ST_IDLE;
               else if (RX_END) state_reg <= sdlc_buf_pkg::ST_DRAIN;
            sdlc_buf_pkg::ST_DRAIN:
               if (q_cnt_reg == 2'd0) state_reg <= sdlc_buf_pkg::ST_IDLE;
            default: state_reg <= sdlc_buf_pkg::ST_IDLE;
         endcase
      end
   end

   // Buffer address, remaining count and accepted count
   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         addr_reg <= sdlc_buf_pkg::REG_RST;
         rem_reg  <= sdlc_buf_pkg::REG_RST;
         acc_reg  <= sdlc_buf_pkg::REG_RST;
      end else begin
         if (wr_en && PADDR == sdlc_buf_pkg::REM_OFS) rem_reg <= PWDATA[7:0];
         if (tx_go) begin
            addr_reg <= txs_reg;
            rem_reg  <= txl_reg;
         end else if (rx_go) begin
            addr_reg <= rxs_reg;
            rem_reg  <= rxl_reg;
            acc_reg  <= 8'h00;
         end else if (state_reg == sdlc_buf_pkg::ST_SEND && TX_READY) begin
            addr_reg <= 8'(addr_reg + 8'd1);
            rem_reg  <= 8'(rem_reg - 8'd1);
         end else begin
            if (pop) addr_reg <= 8'(addr_reg + 8'd1);
            if (push) begin
               acc_reg <= 8'(acc_reg + 8'd1);
               rem_reg <= 8'(rem_reg - 8'd1);
            end
         end
      end
   end

   // ==========================================================
   // Receive queue; entries shift toward the head on each RAM write
   assign wr_idx = pop ? 2'(q_cnt_reg - 2'd1) : q_cnt_reg;
   genvar gi;
   generate
      for (gi = 0; gi < sdlc_buf_pkg::Q_DEPTH; gi++) begin : g_q
         always_ff @(posedge CLK_SYS or negedge RESETN) begin
            if (!RESETN) begin
               q_reg[gi] <= sdlc_buf_pkg::REG_RST;
            end else if (push && wr_idx == 2'(gi)) begin
               q_reg[gi] <= RX_BYTE;
            end else if (pop && gi < 2) begin
               q_reg[gi] <= q_reg[(gi < 2) ? gi + 1 : gi];
            end
         end
      end
   endgenerate

   // Queue fill; an abort zeroes the count, and the queue head still pops to RAM that cycle
   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         q_cnt_reg <= 2'd0;
      end else if (state_reg == sdlc_buf_pkg::ST_RXINF && RX_ABORT) begin
         q_cnt_reg <= 2'd0;
      end else begin
         q_cnt_reg <= 2'(q_cnt_reg + 2'(push) - 2'(pop));
      end
   end

   // ==========================================================
   // Received frame results; control byte held until frame accepted
   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         ctl_hold_reg <= sdlc_buf_pkg::REG_RST;
         rfl_reg      <= sdlc_buf_pkg::REG_RST;
         rcb_reg      <= sdlc_buf_pkg::REG_RST;
      end else begin
         if (state_reg == sdlc_buf_pkg::ST_RXINF && RX_CTRL_VALID) ctl_hold_reg <= RX_CTRL_DATA;
         if (wr_en && PADDR == sdlc_buf_pkg::RFL_OFS) rfl_reg <= PWDATA[7:0];
         if (rx_done) begin
            rfl_reg <= acc_reg;
            if (!mode_reg.nb) rcb_reg <= ctl_hold_reg;
         end
      end
   end

   // RAM port: reads for transmit, writes from the queue head
   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         RAM_ADDR  <= 8'h00;
         RAM_WDATA <= 8'h00;
         RAM_WE    <= 1'b0;
         RAM_RE    <= 1'b0;
      end else begin
         RAM_WE <= pop;
         RAM_RE <= (state_reg == sdlc_buf_pkg::ST_FETCH) && (rem_reg != 8'h00)
                   && (addr_reg <= sdlc_buf_pkg::RAM_TOP);
         if (pop) begin
            RAM_ADDR  <= addr_reg;
            RAM_WDATA <= q_reg[0];
         end else if (state_reg == sdlc_buf_pkg::ST_FETCH) begin
            RAM_ADDR <= addr_reg;
         end
      end
   end

   // ==========================================================
   // Transmit side towards the frame engine
   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         TX_START     <= 1'b0;
         TX_CTRL      <= 8'h00;
         TX_CTRL_EN   <= 1'b0;
         TX_DATA      <= 8'h00;
         TX_VALID     <= 1'b0;
         TX_END       <= 1'b0;
         STATION_ADDR <= 8'h00;
      end else begin
         STATION_ADDR <= station_address_reg;
         TX_START     <= tx_go;
         TX_END       <= state_reg == sdlc_buf_pkg::ST_DONE;
         if (tx_go) begin
            // Automatic mode builds an I-frame control byte itself
            TX_CTRL    <= mode_reg.am ? {seq_reg.nr, 1'b1, seq_reg.ns, 1'b0} : txc_reg;
            TX_CTRL_EN <= !mode_reg.nb;
         end
         if (state_reg == sdlc_buf_pkg::ST_WAIT) begin
            TX_DATA  <= RAM_RDATA;
            TX_VALID <= 1'b1;
         end else if (state_reg == sdlc_buf_pkg::ST_SEND && TX_READY) begin
            TX_VALID <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RESETN);

   // Fetch with nothing left decides the frame end, zero length included
   sequence s_last_byte;
      state_reg == sdlc_buf_pkg::ST_FETCH && rem_reg == 8'h00;
   endsequence
   sequence s_tx_close;
      state_reg == sdlc_buf_pkg::ST_DONE ##1 (TX_END && !mode_reg.transmit_buffer_full);
   endsequence

   a_tbf_cleared: assert property (s_last_byte |=> s_tx_close)
      else $error("Buffer full not cleared after last byte");
   a_top_stops: assert property (state_reg == sdlc_buf_pkg::ST_SEND && TX_READY
         && addr_reg == sdlc_buf_pkg::RAM_TOP |=> state_reg == sdlc_buf_pkg::ST_DONE)
      else $error("Transmit ran past RAM top");
   a_flex_ctrl: assert property (tx_go && !mode_reg.am |=> TX_START && TX_CTRL == $past(txc_reg))
      else $error("Control byte not taken from register");
   a_ser_flag: assert property (ser_hit |=> seq_reg.receive_sequence_error)
      else $error("Receive sequence error not flagged");
   a_ses_flag: assert property (ses_hit |=> seq_reg.send_sequence_error && !mode_reg.am)
      else $error("Send sequence error not flagged");
   a_nr_wrap: assert property (nr_step && !seq_wr |=> seq_reg.nr == 3'($past(seq_reg.nr) + 3'd1))
      else $error("Receive counter did not step");
   a_flex_hold: assert property (!mode_reg.am && !seq_wr |=> $stable(seq_reg))
      else $error("Counters moved outside automatic mode");
   a_rx_limit: assert property ((state_reg == sdlc_buf_pkg::ST_RXINF
         || state_reg == sdlc_buf_pkg::ST_DRAIN) |-> acc_reg <= rxl_reg)
      else $error("Stored byte beyond receive limit");
   a_ram_top: assert property (RAM_WE |-> RAM_ADDR <= sdlc_buf_pkg::RAM_TOP)
      else $error("Receive store past RAM top");
   a_rx_close: assert property (rx_done |=> !mode_reg.receive_buffer_empty && rfl_reg == $past(acc_reg))
      else $error("Frame end did not clear empty or load length");
   a_queue_depth: assert property (push && !pop && !RX_ABORT
         |=> q_cnt_reg == 2'($past(q_cnt_reg) + 2'd1))
      else $error("Queue count lost a byte");
endmodule : sdlc_buf_regs
`default_nettype wire
